/* src/cad_datapath.sv */
/*
 arithmetic datapath: 16-bit ALU with status flags, 17x17 multiplier,
 iterative divider and 40-bit DSP accumulator engine behind an APB slave;
 assumes a single pclk domain and a well-behaved APB3 master
*/
// Register access over APB and the placing of the registers were decided locally.
// How it works
// - sixteen-bit ALU adds, subtracts, shifts and does bitwise logic
// - arithmetic treats operands as two's complement unless an op says unsigned
// - add/subtract update carry, zero, negative, overflow and digit carry flags; shifts carry, zero, negative; logic ops zero, negative
// - on subtract, carry means no borrow and digit carry means no digit borrow
// - command byte bit selects eight-bit or sixteen-bit operand size
// - operands come from register or memory sources; results return to either
// - one 17x17 signed array forms unsigned, signed and mixed products
// - integer multiplies: SS, UU, SU, US, by 5-bit literal, byte by byte
// - divider handles signed and unsigned 32/16 and 16/16 divides
// - long dividend is a register pair, high register holding upper half
// - divider resolves quotient bits per cycle, same time long or short
// - every divide finishes within six cycles
// - DSP: 17x17 multiplier, 40-bit shifter, 40-bit adder, two accumulators
// - accumulator-only add, subtract, negate, minimum and maximum
// - control selects fractional or integer and signed/unsigned/mixed DSP multiply
// - control selects conventional or convergent rounding on accumulator store
// - separate saturation enables for A, B, memory writes, plus saturation mode
// - multiply-accumulate ops take X and Y operands in the same cycle
`timescale 1ns/1ns
`include "cad_regs.svh"
module cad_datapath import cad_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	logic [7:0] core_control_word_reg, core_control_word_next;
	logic [15:0] opa_reg, opa_next, opb_reg, opb_next, ophi_reg, ophi_next;
	logic [4:0] processor_status_word_reg, processor_status_word_next;
	logic [15:0] result_lo_reg, result_lo_next, result_hi_reg, result_hi_next;
	logic [39:0] accumulator_a_reg, accumulator_a_next;
	logic [39:0] accumulator_b_reg, accumulator_b_next;
	logic [31:0] prdata_reg, prdata_next;

	logic wr, rd_setup, mapped, busy, cmd_go, byte_m, accumulator_b_sel, sat_en, frac;
	cad_op_t cmd_op;
	logic [1:0] sgn;
	logic [15:0] alu_b, alu_res;
	logic [16:0] sum_w, dxy, mul_a, mul_b;
	logic [8:0] sum_b;
	logic [4:0] sum_n, alu_f;
	logic a_msb, b_msb, r_msb;
	logic [33:0] prod;
	logic [39:0] p40, tgt, oth, acc_new;
	logic [40:0] acc_sum, shifted, rounded;
	logic [5:0] sh;
	logic rbit;
	logic [15:0] store_word;
	logic div_start, div_busy, div_done, div_ovf, div_signed;
	logic [15:0] div_q, div_r;
	logic [31:0] div_dividend;

	// clamp a 41-bit true result; narrow mode keeps the 1.31 range, wide the full 9.31
	function automatic logic [39:0] sat40(input logic [40:0] v, input logic en,
		input logic wide);
		logic ovf;
		ovf = wide ? (v[40] != v[39]) : !((&v[40:31]) || !(|v[40:31]));
		if (!en || !ovf)
			return v[39:0];
		if (wide)
			return v[40] ? 40'h8000000000 : 40'h7fffffffff;
		return v[40] ? 40'hff80000000 : 40'h007fffffff;
	endfunction : sat40

	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & !penable & !pwrite;
	assign busy = div_busy | div_done;
	assign cmd_op = cad_op_t'(pwdata[`CAD_CMD_OP_MSB:`CAD_CMD_OP_LSB]);
	assign byte_m = pwdata[`CAD_CMD_BYTE];
	assign accumulator_b_sel = pwdata[`CAD_CMD_ACCUMULATOR_B];
	assign cmd_go = wr && (paddr == `CAD_CMD_OFF) && !busy;
	assign frac = !core_control_word_reg[`CAD_CTL_INT];
	assign sgn = core_control_word_reg[`CAD_CTL_SGN_MSB:`CAD_CTL_SGN_LSB];
	assign div_signed = (cmd_op == OP_DIV_S32) || (cmd_op == OP_DIV_S16);
	assign div_start = cmd_go && (cmd_op inside {OP_DIV_S32, OP_DIV_U32, OP_DIV_S16,
		OP_DIV_U16});

	always_comb begin
		div_dividend = {ophi_reg, opa_reg};
		if (cmd_op == OP_DIV_S16)
			div_dividend = {{16{opa_reg[15]}}, opa_reg};
		else if (cmd_op == OP_DIV_U16)
			div_dividend = {16'h0000, opa_reg};
	end

	cad_divider #(
		.QBITS(`CAD_DIV_QBITS),
		.STEP(`CAD_DIV_STEP)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(div_start),
		.is_signed(div_signed),
		.dividend(div_dividend),
		.divisor(opb_reg),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_q),
		.remainder(div_r),
		.overflow(div_ovf)
	);

	// integer ALU
	always_comb begin
		alu_b = (cmd_op == OP_SUB) ? ~opb_reg : opb_reg;
		sum_w = {1'b0, opa_reg} + {1'b0, alu_b} + {16'h0000, cmd_op == OP_SUB};
		sum_b = {1'b0, opa_reg[7:0]} + {1'b0, alu_b[7:0]} + {8'h00, cmd_op == OP_SUB};
		sum_n = {1'b0, opa_reg[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cmd_op == OP_SUB};
		alu_f = processor_status_word_reg;
		alu_res = opa_reg;
		case (cmd_op)
			OP_ADD, OP_SUB: begin
				alu_res = byte_m ? {opa_reg[15:8], sum_b[7:0]} : sum_w[15:0];
				alu_f[`CAD_PSW_C] = byte_m ? sum_b[8] : sum_w[16];
				alu_f[`CAD_PSW_DC] = sum_n[4];
			end
			OP_AND: alu_res = opa_reg & opb_reg;
			OP_IOR: alu_res = opa_reg | opb_reg;
			OP_XOR: alu_res = opa_reg ^ opb_reg;
			OP_SHL: begin
				alu_res = byte_m ? {opa_reg[15:8], opa_reg[6:0], 1'b0} : {opa_reg[14:0], 1'b0};
				alu_f[`CAD_PSW_C] = byte_m ? opa_reg[7] : opa_reg[15];
			end
			OP_LSR, OP_ASR: begin
				alu_res = {(cmd_op == OP_ASR) & opa_reg[15], opa_reg[15:1]};
				if (byte_m)
					alu_res = {opa_reg[15:8], (cmd_op == OP_ASR) & opa_reg[7], opa_reg[7:1]};
				alu_f[`CAD_PSW_C] = opa_reg[0];
			end
			default: alu_res = opa_reg;
		endcase
		// byte ops leave the upper byte of the destination untouched
		if (byte_m && (cmd_op inside {OP_AND, OP_IOR, OP_XOR}))
			alu_res[15:8] = opa_reg[15:8];
		a_msb = byte_m ? opa_reg[7] : opa_reg[15];
		b_msb = byte_m ? alu_b[7] : alu_b[15];
		r_msb = byte_m ? alu_res[7] : alu_res[15];
		alu_f[`CAD_PSW_Z] = byte_m ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
		alu_f[`CAD_PSW_N] = r_msb;
		if (cmd_op inside {OP_ADD, OP_SUB})
			alu_f[`CAD_PSW_OV] = (a_msb == b_msb) && (r_msb != a_msb);
	end

	// shared multiplier: X and Y taken together in one cycle
	always_comb begin
		dxy = {opa_reg[15], opa_reg} - {opb_reg[15], opb_reg};
		mul_a = {opa_reg[15], opa_reg};
		mul_b = {opb_reg[15], opb_reg};
		case (cmd_op)
			OP_MUL_UU: begin
				mul_a = {1'b0, opa_reg};
				mul_b = {1'b0, opb_reg};
			end
			OP_MUL_SU: mul_b = {1'b0, opb_reg};
			OP_MUL_US: mul_a = {1'b0, opa_reg};
			OP_MUL_SLIT: mul_b = {12'h000, opb_reg[4:0]};
			OP_MUL_ULIT: begin
				mul_a = {1'b0, opa_reg};
				mul_b = {12'h000, opb_reg[4:0]};
			end
			OP_MUL_BB: begin
				mul_a = {9'h000, opa_reg[7:0]};
				mul_b = {9'h000, opb_reg[7:0]};
			end
			OP_ED, OP_EDAC: begin
				mul_a = dxy;
				mul_b = dxy;
			end
			OP_MAC, OP_MSC, OP_MPY, OP_MPYN: begin
				if (sgn == `CAD_SGN_UNSIGNED) begin
					mul_a = {1'b0, opa_reg};
					mul_b = {1'b0, opb_reg};
				end else if (sgn == `CAD_SGN_MIXED) begin
					mul_a = {1'b0, opa_reg};
				end
			end
			default: mul_a = {opa_reg[15], opa_reg};
		endcase
		prod = $signed({{17{mul_a[16]}}, mul_a}) * $signed({{17{mul_b[16]}}, mul_b});
		p40 = frac ? {{5{prod[33]}}, prod, 1'b0} : {{6{prod[33]}}, prod};
	end

	// 40-bit accumulator engine
	always_comb begin
		tgt = accumulator_b_sel ? accumulator_b_reg : accumulator_a_reg;
		oth = accumulator_b_sel ? accumulator_a_reg : accumulator_b_reg;
		sat_en = accumulator_b_sel ? core_control_word_reg[`CAD_CTL_ACC_B_SATURATE_ENABLE] :
			core_control_word_reg[`CAD_CTL_ACC_A_SATURATE_ENABLE];
		sh = opa_reg[5:0];
		shifted = sh[5] ? ({tgt[39], tgt} << (6'h00 - sh)) :
			41'($signed({tgt[39], tgt}) >>> sh);
		case (cmd_op)
			OP_ACC_ADD: acc_sum = {tgt[39], tgt} + {oth[39], oth};
			OP_ACC_SUB: acc_sum = {tgt[39], tgt} - {oth[39], oth};
			OP_ACC_NEG: acc_sum = 41'h00000000000 - {tgt[39], tgt};
			OP_ACC_MIN: acc_sum = ($signed(tgt) < $signed(oth)) ? {tgt[39], tgt} : {oth[39], oth};
			OP_ACC_MAX: acc_sum = ($signed(tgt) > $signed(oth)) ? {tgt[39], tgt} : {oth[39], oth};
			OP_ACC_SFT: acc_sum = shifted;
			OP_ED, OP_MPY: acc_sum = {p40[39], p40};
			OP_MPYN: acc_sum = 41'h00000000000 - {p40[39], p40};
			OP_EDAC, OP_MAC: acc_sum = {tgt[39], tgt} + {p40[39], p40};
			OP_MSC: acc_sum = {tgt[39], tgt} - {p40[39], p40};
			default: acc_sum = 41'h00000000000;
		endcase
		acc_new = sat40(acc_sum, sat_en, core_control_word_reg[`CAD_CTL_SATURATION_WIDTH_SELECT]);
		// convergent rounding only differs on an exact half: then round to even
		rbit = tgt[15];
		if (core_control_word_reg[`CAD_CTL_RND] && (tgt[15:0] == 16'h8000))
			rbit = tgt[16];
		rounded = {tgt[39], tgt} + {24'h000000, rbit, 16'h0000};
		store_word = rounded[31:16];
		if (core_control_word_reg[`CAD_CTL_MEMORY_WRITE_SATURATE_ENABLE] && !((&rounded[40:31]) || !(|rounded[40:31])))
			store_word = rounded[40] ? 16'h8000 : 16'h7fff;
	end

	// register file and command execution
	always_comb begin
		core_control_word_next = core_control_word_reg;
		opa_next = opa_reg;
		opb_next = opb_reg;
		ophi_next = ophi_reg;
		processor_status_word_next = processor_status_word_reg;
		result_lo_next = result_lo_reg;
		result_hi_next = result_hi_reg;
		accumulator_a_next = accumulator_a_reg;
		accumulator_b_next = accumulator_b_reg;
		prdata_next = prdata_reg;
		if (wr) begin
			case (paddr)
				`CAD_CTRL_OFF: core_control_word_next = pwdata[7:0];
				`CAD_OPA_OFF: opa_next = pwdata[15:0];
				`CAD_OPB_OFF: opb_next = pwdata[15:0];
				`CAD_OPHI_OFF: ophi_next = pwdata[15:0];
				default: opa_next = opa_reg;
			endcase
		end
		if (cmd_go) begin
			case (cmd_op)
				OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_LSR, OP_ASR: begin
					result_lo_next = alu_res;
					processor_status_word_next = alu_f;
				end
				OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_SLIT, OP_MUL_ULIT,
				OP_MUL_BB: begin
					result_lo_next = prod[15:0];
					result_hi_next = prod[31:16];
				end
				OP_ACC_ADD, OP_ACC_SUB, OP_ACC_NEG, OP_ACC_MIN, OP_ACC_MAX, OP_ACC_SFT, OP_ED,
				OP_EDAC, OP_MAC, OP_MSC, OP_MPY, OP_MPYN, OP_CLR: begin
					if (accumulator_b_sel)
						accumulator_b_next = (cmd_op == OP_CLR) ? 40'h0000000000 : acc_new;
					else
						accumulator_a_next = (cmd_op == OP_CLR) ? 40'h0000000000 : acc_new;
				end
				OP_MOVSAC: result_lo_next = store_word;
				default: result_lo_next = result_lo_reg;
			endcase
		end
		if (div_done) begin
			result_lo_next = div_q;
			result_hi_next = div_r;
			processor_status_word_next[`CAD_PSW_OV] = div_ovf;
			processor_status_word_next[`CAD_PSW_Z] = (div_q == 16'h0000);
			processor_status_word_next[`CAD_PSW_N] = div_q[15];
		end
		if (rd_setup) begin
			case (paddr)
				`CAD_CTRL_OFF: prdata_next = {24'h000000, core_control_word_reg};
				`CAD_OPA_OFF: prdata_next = {16'h0000, opa_reg};
				`CAD_OPB_OFF: prdata_next = {16'h0000, opb_reg};
				`CAD_OPHI_OFF: prdata_next = {16'h0000, ophi_reg};
				`CAD_PSW_OFF: prdata_next = {23'h000000, busy, 3'h0, processor_status_word_reg};
				`CAD_RESLO_OFF: prdata_next = {16'h0000, result_lo_reg};
				`CAD_RESHI_OFF: prdata_next = {16'h0000, result_hi_reg};
				`CAD_ACCAL_OFF: prdata_next = accumulator_a_reg[31:0];
				`CAD_ACCAH_OFF: prdata_next = {24'h000000, accumulator_a_reg[39:32]};
				`CAD_ACCBL_OFF: prdata_next = accumulator_b_reg[31:0];
				`CAD_ACCBH_OFF: prdata_next = {24'h000000, accumulator_b_reg[39:32]};
				default: prdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_control_word_reg <= `CAD_CTL_RESET;
			opa_reg <= 16'h0000;
			opb_reg <= 16'h0000;
			ophi_reg <= 16'h0000;
			processor_status_word_reg <= `CAD_PSW_RESET;
			result_lo_reg <= 16'h0000;
			result_hi_reg <= 16'h0000;
			accumulator_a_reg <= 40'h0000000000;
			accumulator_b_reg <= 40'h0000000000;
			prdata_reg <= 32'h00000000;
		end else begin
			core_control_word_reg <= core_control_word_next;
			opa_reg <= opa_next;
			opb_reg <= opb_next;
			ophi_reg <= ophi_next;
			processor_status_word_reg <= processor_status_word_next;
			result_lo_reg <= result_lo_next;
			result_hi_reg <= result_hi_next;
			accumulator_a_reg <= accumulator_a_next;
			accumulator_b_reg <= accumulator_b_next;
			prdata_reg <= prdata_next;
		end
	end

	always_comb begin
		case (paddr)
			`CAD_CTRL_OFF, `CAD_OPA_OFF, `CAD_OPB_OFF, `CAD_OPHI_OFF, `CAD_CMD_OFF,
			`CAD_PSW_OFF, `CAD_RESLO_OFF, `CAD_RESHI_OFF, `CAD_ACCAL_OFF, `CAD_ACCAH_OFF,
			`CAD_ACCBL_OFF, `CAD_ACCBH_OFF: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// zero-wait slave; read data was captured during the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & !mapped;
	assign prdata = prdata_reg;

endmodule : cad_datapath

/* src/cad_regs.svh */
/*
 register offsets, field positions, reset values and timing counts of the
 arithmetic datapath; assumes a 12-bit APB byte address
*/
`ifndef CAD_REGS_SVH
`define CAD_REGS_SVH

`define CAD_CTRL_OFF 12'h000
`define CAD_OPA_OFF 12'h004
`define CAD_OPB_OFF 12'h008
`define CAD_OPHI_OFF 12'h00c
`define CAD_CMD_OFF 12'h010
`define CAD_PSW_OFF 12'h014
`define CAD_RESLO_OFF 12'h018
`define CAD_RESHI_OFF 12'h01c
`define CAD_ACCAL_OFF 12'h020
`define CAD_ACCAH_OFF 12'h024
`define CAD_ACCBL_OFF 12'h028
`define CAD_ACCBH_OFF 12'h02c

// core_control_word fields
`define CAD_CTL_INT 0
`define CAD_CTL_SGN_LSB 1
`define CAD_CTL_SGN_MSB 2
`define CAD_CTL_RND 3
`define CAD_CTL_ACC_A_SATURATE_ENABLE 4
`define CAD_CTL_ACC_B_SATURATE_ENABLE 5
`define CAD_CTL_MEMORY_WRITE_SATURATE_ENABLE 6
`define CAD_CTL_SATURATION_WIDTH_SELECT 7
`define CAD_CTL_RESET 8'h00
`define CAD_SGN_UNSIGNED 2'h1
`define CAD_SGN_MIXED 2'h2

// command word fields
`define CAD_CMD_OP_LSB 0
`define CAD_CMD_OP_MSB 5
`define CAD_CMD_BYTE 8
`define CAD_CMD_ACCUMULATOR_B 9

// processor_status_word fields
`define CAD_PSW_C 0
`define CAD_PSW_Z 1
`define CAD_PSW_N 2
`define CAD_PSW_OV 3
`define CAD_PSW_DC 4
`define CAD_PSW_BUSY 8
`define CAD_PSW_RESET 5'h00

// divider: quotient bits and bits resolved per clock
`define CAD_DIV_QBITS 16
`define CAD_DIV_STEP 3

`endif

/* src/cad_pkg.sv */
/*
 types of the arithmetic datapath: command codes and divider states;
 assumes nothing beyond the register header
*/
package cad_pkg;

	typedef enum logic [5:0] {
		OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_LSR, OP_ASR,
		OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_SLIT, OP_MUL_ULIT, OP_MUL_BB,
		OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16,
		OP_ACC_ADD, OP_ACC_SUB, OP_ACC_NEG, OP_ACC_MIN, OP_ACC_MAX, OP_ACC_SFT,
		OP_CLR, OP_ED, OP_EDAC, OP_MAC, OP_MSC, OP_MPY, OP_MPYN, OP_MOVSAC, OP_NOP
	} cad_op_t;

	typedef enum logic [0:0] {
		DIV_IDLE, DIV_RUN
	} cad_div_state_t;

endpackage : cad_pkg

/* src/cad_divider.sv */
/*
 iterative restoring divider, 32/16 and 16/16, signed or unsigned;
 assumes operands stay meaningful only at start, all on pclk
*/
`timescale 1ns/1ns
`include "cad_regs.svh"
module cad_divider import cad_pkg::*; #(
	parameter int QBITS = `CAD_DIV_QBITS,
	parameter int STEP = `CAD_DIV_STEP
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic is_signed,
	input wire logic [31:0] dividend,
	input wire logic [15:0] divisor,
	output logic busy,
	output logic done,
	output logic [15:0] quotient,
	output logic [15:0] remainder,
	output logic overflow
);
	localparam logic [4:0] QB = 5'(QBITS);

	cad_div_state_t state_reg, state_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [15:0] rem_reg, rem_next, dlo_reg, dlo_next, dv_reg, dv_next;
	logic neg_q_reg, neg_q_next, neg_r_reg, neg_r_next, ovf_reg, ovf_next;
	logic done_reg, done_next, sgn_reg, sgn_next;
	logic [15:0] quot_reg, quot_next, remo_reg, remo_next;
	logic [31:0] dmag;
	logic [15:0] vmag, qs;
	logic [16:0] t;
	logic dsg, vsg;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		rem_next = rem_reg;
		dlo_next = dlo_reg;
		dv_next = dv_reg;
		neg_q_next = neg_q_reg;
		neg_r_next = neg_r_reg;
		ovf_next = ovf_reg;
		quot_next = quot_reg;
		remo_next = remo_reg;
		sgn_next = sgn_reg;
		done_next = 1'b0;
		t = 17'h00000;
		qs = 16'h0000;
		dsg = is_signed & dividend[31];
		vsg = is_signed & divisor[15];
		dmag = dsg ? 32'h00000000 - dividend : dividend;
		vmag = vsg ? 16'h0000 - divisor : divisor;
		case (state_reg)
			DIV_IDLE: begin
				if (start) begin
					state_next = DIV_RUN;
					cnt_next = 5'h00;
					rem_next = dmag[31:16];
					dlo_next = dmag[15:0];
					dv_next = vmag;
					neg_q_next = dsg ^ vsg;
					neg_r_next = dsg;
					// the command bus moves on after start, so keep the sign mode here
					sgn_next = is_signed;
					// quotient must fit 16 bits, so the upper half must stay below the divisor
					ovf_next = (vmag == 16'h0000) | (dmag[31:16] >= vmag);
				end
			end
			DIV_RUN: begin
				// several single-bit steps per clock keep the divide within six cycles
				for (int k = 0; k < STEP; k++) begin
					if (cnt_next < QB) begin
						t = {rem_next, dlo_next[15]};
						dlo_next = {dlo_next[14:0], 1'b0};
						if (t >= {1'b0, dv_reg}) begin
							t = t - {1'b0, dv_reg};
							dlo_next[0] = 1'b1;
						end
						rem_next = t[15:0];
						cnt_next = cnt_next + 5'h01;
					end
				end
				if (cnt_next == QB) begin
					qs = neg_q_reg ? 16'h0000 - dlo_next : dlo_next;
					if (sgn_reg && (neg_q_reg ? dlo_next > 16'h8000 : dlo_next[15]))
						ovf_next = 1'b1;
					quot_next = qs;
					remo_next = neg_r_reg ? 16'h0000 - rem_next : rem_next;
					done_next = 1'b1;
					state_next = DIV_IDLE;
				end
			end
			default: state_next = DIV_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= DIV_IDLE;
			cnt_reg <= 5'h00;
			rem_reg <= 16'h0000;
			dlo_reg <= 16'h0000;
			dv_reg <= 16'h0000;
			neg_q_reg <= 1'b0;
			neg_r_reg <= 1'b0;
			ovf_reg <= 1'b0;
			quot_reg <= 16'h0000;
			remo_reg <= 16'h0000;
			done_reg <= 1'b0;
			sgn_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			rem_reg <= rem_next;
			dlo_reg <= dlo_next;
			dv_reg <= dv_next;
			neg_q_reg <= neg_q_next;
			neg_r_reg <= neg_r_next;
			ovf_reg <= ovf_next;
			quot_reg <= quot_next;
			remo_reg <= remo_next;
			done_reg <= done_next;
			sgn_reg <= sgn_next;
		end
	end

	assign busy = (state_reg == DIV_RUN);
	assign done = done_reg;
	assign quotient = quot_reg;
	assign remainder = remo_reg;
	assign overflow = ovf_reg;

endmodule : cad_divider

/* test/cad_datapath_monitor.sv */
/*
 apb port assertions of the arithmetic datapath
 assumes one pclk domain and a zero wait state slave
*/
`timescale 1ns/1ns
`include "cad_regs.svh"
module cad_datapath_monitor import cad_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic [3:0] div_age_reg;
	logic [3:0] div_age_next;
	logic rd_acc;
	logic div_wr;
	assign rd_acc = psel && penable && !pwrite;
	// a command written while busy is dropped, so it does not restart the count
	assign div_wr = psel && penable && pwrite && paddr == `CAD_CMD_OFF && div_age_reg >= 4'h7
		&& pwdata[5:0] >= OP_DIV_S32 && pwdata[5:0] <= OP_DIV_U16;
	always_comb begin
		div_age_next = div_age_reg;
		if (div_wr) begin
			div_age_next = 4'h0;
		end else if (div_age_reg != 4'hf) begin
			div_age_next = div_age_reg + 4'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_age_reg <= 4'hf;
		end else begin
			div_age_reg <= div_age_next;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_err_unmapped: assert property (psel && penable && paddr > `CAD_ACCBH_OFF |-> pslverr)
		else $error("unmapped access gave no error");
	a_err_mapped: assert property (psel && penable && paddr <= `CAD_ACCBH_OFF
		&& paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access gave error");
	a_err_idle: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access phase");
	a_rd_hold: assert property (rd_acc |=> $stable(prdata))
		else $error("read data moved after access");
	a_cmd_zero: assert property (rd_acc && (paddr == `CAD_CMD_OFF
		|| paddr > `CAD_ACCBH_OFF) |-> prdata == 32'h0) else $error("command read not zero");
	a_psw_width: assert property (rd_acc && paddr == `CAD_PSW_OFF
		|-> prdata[31:9] == 23'h0 && prdata[7:5] == 3'h0) else $error("status spare bits set");
	a_acc_width: assert property (rd_acc && (paddr == `CAD_ACCAH_OFF
		|| paddr == `CAD_ACCBH_OFF) |-> prdata[31:8] == 24'h0) else $error("accumulator over 40 bits");
	a_div_busy: assert property (rd_acc && paddr == `CAD_PSW_OFF
		&& div_age_reg inside {[1:7]} |-> prdata[8]) else $error("busy low during divide");
	a_div_six: assert property (rd_acc && paddr == `CAD_PSW_OFF
		&& div_age_reg >= 4'h8 |-> !prdata[8]) else $error("divide longer than six cycles");
endmodule : cad_datapath_monitor

bind cad_datapath cad_datapath_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));

/* test/cad_host_model.sv */
/*
 apb master standing in for the decoder and operand sources
 assumes the slave answers with pready on pclk
*/
`timescale 1ns/1ns
module cad_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic hung
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		hung = 1'b0;
	end
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			hung <= 1'b1;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data must not look valid
		pwdata <= ~d;
	endtask : xfer
endmodule : cad_host_model

/* test/test_cpu_arith_dsp_datapath.sv */
/*
 self-checking bench of the arithmetic datapath
 assumes results land in the result and accumulator words
*/
`timescale 1ns/1ns
`include "cad_regs.svh"
module test_cpu_arith_dsp_datapath import cad_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	int error_cnt, total_checks;
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	cad_datapath i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	cad_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hung(hung));
	task automatic results();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		i_host.xfer(1'b1, a, d, r, e);
	endtask : wr
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		i_host.xfer(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask : rdchk
	task automatic op(input cad_op_t o, input logic [31:0] a, input logic [31:0] b,
		input logic [1:0] f);
		wr(`CAD_OPA_OFF, a);
		wr(`CAD_OPB_OFF, b);
		wr(`CAD_CMD_OFF, {22'h0, f, 2'h0, o});
	endtask : op
	task automatic wait_idle();
		logic [31:0] r;
		logic e;
		int n;
		n = 0;
		do begin
			i_host.xfer(1'b0, `CAD_PSW_OFF, 32'h0, r, e);
			n++;
		end while (r[8] !== 1'b0 && n < 20);
		chk({31'h0, r[8]}, 32'h0);
	endtask : wait_idle
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rdchk(`CAD_CTRL_OFF, 32'h0);
		rdchk(`CAD_PSW_OFF, 32'h0);
		i_host.xfer(1'b0, 12'h100, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
	endtask : t_reset
	task automatic t_alu();
		op(OP_ADD, 32'h7fff, 32'h1, 2'h0);
		rdchk(`CAD_RESLO_OFF, 32'h8000);
		rdchk(`CAD_PSW_OFF, 32'h1c);
		op(OP_SUB, 32'h5, 32'h5, 2'h0);
		rdchk(`CAD_PSW_OFF, 32'h13);
		op(OP_SUB, 32'h3, 32'h5, 2'h0);
		rdchk(`CAD_PSW_OFF, 32'h04);
		op(OP_ADD, 32'h12ff, 32'h1, 2'h1);
		rdchk(`CAD_RESLO_OFF, 32'h1200);
		rdchk(`CAD_PSW_OFF, 32'h13);
		op(OP_XOR, 32'h00f0, 32'h0ff0, 2'h0);
		rdchk(`CAD_RESLO_OFF, 32'h0f00);
		op(OP_ASR, 32'h8002, 32'h0, 2'h0);
		rdchk(`CAD_RESLO_OFF, 32'hc001);
	endtask : t_alu
	task automatic t_mul();
		cad_op_t ops [7] = '{OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_SLIT,
			OP_MUL_ULIT, OP_MUL_BB};
		logic [15:0] av [7] = '{16'hffff, 16'hffff, 16'hffff, 16'h2, 16'hffff, 16'hffff, 16'h12ff};
		logic [15:0] bv [7] = '{16'h2, 16'h2, 16'hffff, 16'hffff, 16'h3f, 16'h21, 16'h34ff};
		logic [31:0] pv [7] = '{32'hfffffffe, 32'h1fffe, 32'hffff0001, 32'hfffffffe,
			32'hffffffe1, 32'hffff, 32'hfe01};
		for (int i = 0; i < 7; i++) begin
			op(ops[i], {16'h0, av[i]}, {16'h0, bv[i]}, 2'h0);
			rdchk(`CAD_RESLO_OFF, {16'h0, pv[i][15:0]});
			rdchk(`CAD_RESHI_OFF, {16'h0, pv[i][31:16]});
		end
	endtask : t_mul
	task automatic t_div();
		wr(`CAD_OPHI_OFF, 32'h1);
		op(OP_DIV_U32, 32'h0, 32'h3, 2'h0);
		// busy plus the digit carry and negative flags left by the last shift
		rdchk(`CAD_PSW_OFF, 32'h114);
		// issued while busy, so it must leave the quotient and the carries alone
		wr(`CAD_CMD_OFF, {26'h0, OP_ADD});
		wait_idle();
		rdchk(`CAD_RESLO_OFF, 32'h5555);
		rdchk(`CAD_PSW_OFF, 32'h10);
		op(OP_DIV_S16, 32'hfff9, 32'h2, 2'h0);
		wait_idle();
		rdchk(`CAD_RESLO_OFF, 32'hfffd);
		// quotient 0x8000 does not fit a signed word
		op(OP_DIV_S16, 32'h8000, 32'hffff, 2'h0);
		wait_idle();
		rdchk(`CAD_PSW_OFF, 32'h1c);
	endtask : t_div
	task automatic t_acc();
		cad_op_t ops [7] = '{OP_MPY, OP_MAC, OP_MSC, OP_ED, OP_EDAC, OP_ACC_NEG, OP_CLR};
		logic [31:0] ev [7] = '{32'hc, 32'h18, 32'hc, 32'h9, 32'h12, 32'hffffffee, 32'h0};
		wr(`CAD_CTRL_OFF, 32'h1);
		for (int i = 0; i < 7; i++) begin
			op(ops[i], i < 3 ? 32'h3 : 32'h5, i < 3 ? 32'h4 : 32'h2, 2'h0);
			rdchk(`CAD_ACCAL_OFF, ev[i]);
			rdchk(`CAD_ACCAH_OFF, {24'h0, {8{ev[i][31]}}});
		end
		op(OP_MPYN, 32'h3, 32'h4, 2'h2);
		rdchk(`CAD_ACCBH_OFF, 32'hff);
		op(OP_ACC_ADD, 32'h0, 32'h0, 2'h0);
		rdchk(`CAD_ACCAL_OFF, 32'hfffffff4);
	endtask : t_acc
	task automatic t_sat();
		op(OP_MPY, 32'h7fff, 32'h7fff, 2'h0);
		op(OP_ACC_SFT, 32'h38, 32'h0, 2'h0);
		rdchk(`CAD_ACCAH_OFF, 32'h3f);
		wr(`CAD_CTRL_OFF, 32'h11);
		op(OP_MPY, 32'h7fff, 32'h7fff, 2'h0);
		op(OP_ACC_SFT, 32'h38, 32'h0, 2'h0);
		rdchk(`CAD_ACCAL_OFF, 32'h7fffffff);
		rdchk(`CAD_ACCAH_OFF, 32'h0);
		wr(`CAD_CTRL_OFF, 32'h0);
		op(OP_MPY, 32'h3, 32'h4, 2'h0);
		rdchk(`CAD_ACCAL_OFF, 32'h18);
		wr(`CAD_CTRL_OFF, 32'h3);
		op(OP_MPY, 32'hffff, 32'h2, 2'h0);
		rdchk(`CAD_ACCAL_OFF, 32'h1fffe);
		op(OP_MPY, 32'h8000, 32'h1, 2'h0);
		op(OP_MOVSAC, 32'h0, 32'h0, 2'h0);
		rdchk(`CAD_RESLO_OFF, 32'h1);
		// exact half: convergent rounding keeps the even upper word
		wr(`CAD_CTRL_OFF, 32'hb);
		op(OP_MOVSAC, 32'h0, 32'h0, 2'h0);
		rdchk(`CAD_RESLO_OFF, 32'h0);
		rdchk(`CAD_ACCAL_OFF, 32'h8000);
	endtask : t_sat
	always @(posedge hung) begin
		error_cnt++;
		results();
	end
	initial begin
		presetn = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_alu();
		t_mul();
		t_div();
		t_acc();
		t_sat();
		results();
	end
endmodule : test_cpu_arith_dsp_datapath
